// [design/eag_pkg.sv]
// constants and types for the effective-address generator
// Function
// - long direct takes two operand bytes as a full 16-bit address
// - indexed address is unsigned sum of selected index and offset
// - no-offset indexed uses index alone, no operand byte, range 00..FF
// - short-offset indexed adds one offset byte to index, range 000..1FE
// - long-offset indexed adds index to a 16-bit two-byte offset
// - read-modify-write, jump and call classes refuse long-offset indexed forms
// - indirect modes read a pointer address byte, then fetch the pointer
// - short indirect fetches one page-zero byte as address 00..FF
// - long indirect modes fetch a two-byte page-zero pointer
// - indirect-indexed adds index unsigned to fetched pointer
// - relative adds signed 8-bit displacement to program counter, jumps and calls only
// - direct relative takes displacement from byte after opcode
// - indirect relative fetches displacement from memory at given byte address
// - prefix 90 selects Y in place of X
// - prefix 92 converts direct or X-indexed forms to indirect forms
// - prefix 91 converts indirect X-indexed to indirect Y-indexed
package eag_pkg;
   localparam logic [7:0] EAG_PFX_Y     = 8'h90;
   localparam logic [7:0] EAG_PFX_IND_Y = 8'h91;
   localparam logic [7:0] EAG_PFX_IND   = 8'h92;
   localparam logic [7:0] EAG_PAGE0_HI  = 8'h00;
   localparam logic [1:0] EAG_LEN_NONE  = 2'h0;
   localparam logic [1:0] EAG_LEN_ONE   = 2'h1;
   localparam logic [1:0] EAG_LEN_TWO   = 2'h2;

   // base mode as given by the opcode, before any prefix
   typedef enum logic [3:0] {
      EAG_M_DIR_S  = 4'h0,
      EAG_M_DIR_L  = 4'h1,
      EAG_M_IDX_0  = 4'h2,
      EAG_M_IDX_S  = 4'h3,
      EAG_M_IDX_L  = 4'h4,
      EAG_M_REL    = 4'h5,
      EAG_M_IMM    = 4'h6,
      EAG_M_INH    = 4'h7
   } eag_mode_t;

   // instruction class; only the first accepts long forms
   typedef enum logic [1:0] {
      EAG_C_ALU    = 2'h0,
      EAG_C_RMW    = 2'h1,
      EAG_C_JMP    = 2'h2,
      EAG_C_REL    = 2'h3
   } eag_class_t;

   // one-hot sequencer states
   typedef enum logic [6:0] {
      EAG_S_IDLE   = 7'b0000001,
      EAG_S_OPND1  = 7'b0000010,
      EAG_S_OPND2  = 7'b0000100,
      EAG_S_PTR1   = 7'b0001000,
      EAG_S_PTR2   = 7'b0010000,
      EAG_S_DONE   = 7'b0100000,
      EAG_S_ERR    = 7'b1000000
   } eag_state_t;
endpackage

// [design/eag_adder.sv]
// address adder: unsigned index add or signed relative add
`timescale 1ns/1ns
module eag_adder
(
   input  wire logic [15:0] i_base,
   input  wire logic [7:0]  i_addend,
   input  wire logic        i_signed,
   output logic      [15:0] o_sum
);
   logic [15:0] ext;
   always_comb
   begin
      ext   = i_signed ? {{8{i_addend[7]}}, i_addend} : {8'h00, i_addend};
      o_sum = i_base + ext;
   end
endmodule

// [design/eag_core.sv]
// effective-address sequencer: operand fetch, pointer fetch, address sum
`timescale 1ns/1ns
module eag_core
   import eag_pkg::*;
(
   input  wire logic                i_mclk,
   input  wire logic                i_sys_rst,
   input  wire logic                i_start,
   input  wire logic [7:0]          i_prefix,
   input  wire logic                i_prefix_vld,
   input  wire eag_pkg::eag_mode_t  i_mode,
   input  wire eag_pkg::eag_class_t i_class,
   input  wire logic [7:0]          i_x,
   input  wire logic [7:0]          i_y,
   input  wire logic [15:0]         i_pc,
   output logic                     o_mem_req,
   output logic [15:0]              o_mem_addr,
   input  wire logic                i_mem_ack,
   input  wire logic [7:0]          i_mem_rdata,
   output logic                     o_done,
   output logic                     o_illegal,
   output logic [15:0]              o_ea,
   output logic [1:0]               o_opnd_len,
   output logic                     o_use_y,
   output logic                     o_busy
);
   import eag_pkg::*;

   typedef struct packed {
      eag_state_t st;
      logic [15:0] pc;
      logic [15:0] val;
      logic [15:0] ea;
      // page-zero pointer walk, kept apart so o_ea holds between completions
      logic [15:0] ptr;
      logic [7:0]  idx;
      logic [1:0]  opnds;
      logic [1:0]  len;
      logic        two_left;
      logic        ind;
      logic        ind_word;
      logic        add_idx;
      logic        rel;
      logic        use_y;
      logic        done;
      logic        illegal;
   } eag_regs_t;

   eag_regs_t r_q;
   eag_regs_t r_d;
   logic [15:0] sum;
   logic [15:0] add_base;
   logic [7:0]  add_val;

   function automatic logic [15:0] eag_join(input logic [7:0] hi, input logic [7:0] lo);
      eag_join = {hi, lo};
   endfunction

   function automatic logic [15:0] eag_page0(input logic [7:0] lo);
      eag_page0 = {EAG_PAGE0_HI, lo};
   endfunction

   eag_adder u_add
   (
      .i_base   (add_base),
      .i_addend (add_val),
      .i_signed (r_q.rel),
      .o_sum    (sum)
   );

   // relative mode adds displacement (low byte of val) to pc, others add index
   always_comb
   begin
      add_base = r_q.rel ? r_q.pc : r_q.val;
      add_val  = r_q.rel ? r_q.val[7:0] : r_q.idx;
   end

   always_comb
   begin
      logic pfx_y;
      logic pfx_ind;
      logic pfx_indy;
      logic long_form;
      logic bad_long;
      logic bad_rel;
      logic bad_pfx;
      pfx_y     = i_prefix_vld && (i_prefix == EAG_PFX_Y);
      pfx_ind   = i_prefix_vld && (i_prefix == EAG_PFX_IND);
      pfx_indy  = i_prefix_vld && (i_prefix == EAG_PFX_IND_Y);
      long_form = (i_mode == EAG_M_DIR_L) || (i_mode == EAG_M_IDX_L);
      bad_long  = long_form && (i_class != EAG_C_ALU);
      bad_rel   = (i_mode == EAG_M_REL) != (i_class == EAG_C_REL);
      // no-offset indexed has no pointer byte, so it has no indirect Y form
      bad_pfx   = pfx_indy && (i_mode != EAG_M_IDX_S) && (i_mode != EAG_M_IDX_L);
      r_d       = r_q;
      r_d.done  = 1'b0;
      o_mem_req = 1'b0;
      // address idles on pc so a stale pointer never reaches the bus
      o_mem_addr = r_q.pc;
      unique case (r_q.st)
         EAG_S_IDLE:
         begin
            if (i_start)
            begin
               r_d.pc       = i_pc;
               r_d.val      = 16'h0000;
               r_d.illegal  = 1'b0;
               r_d.use_y    = pfx_y || pfx_indy;
               r_d.idx      = (pfx_y || pfx_indy) ? i_y : i_x;
               r_d.ind      = pfx_ind || pfx_indy;
               r_d.add_idx  = (i_mode == EAG_M_IDX_0) || (i_mode == EAG_M_IDX_S)
                              || (i_mode == EAG_M_IDX_L);
               r_d.rel      = (i_mode == EAG_M_REL);
               // long-pointer indirect comes from a long base form with a prefix
               r_d.ind_word = long_form;
               if (pfx_ind || pfx_indy)
                  r_d.opnds = EAG_LEN_ONE;
               else if (long_form)
                  r_d.opnds = EAG_LEN_TWO;
               else if (i_mode == EAG_M_IDX_0 || i_mode == EAG_M_INH)
                  r_d.opnds = EAG_LEN_NONE;
               else
                  r_d.opnds = EAG_LEN_ONE;
               r_d.len      = r_d.opnds;
               r_d.two_left = (r_d.opnds == EAG_LEN_TWO);
               // only alu class may use long forms; relative mode only with the relative class
               if (bad_long || bad_rel || bad_pfx)
                  r_d.st = EAG_S_ERR;
               else if (r_d.opnds == EAG_LEN_NONE)
                  r_d.st = EAG_S_DONE;
               else
                  r_d.st = EAG_S_OPND1;
            end
         end
         EAG_S_OPND1, EAG_S_OPND2:
         begin
            o_mem_req  = 1'b1;
            o_mem_addr = r_q.pc;
            if (i_mem_ack)
            begin
               r_d.pc  = r_q.pc + 16'h0001;
               r_d.val = {r_q.val[7:0], i_mem_rdata};
               if (r_q.two_left)
               begin
                  r_d.two_left = 1'b0;
                  r_d.st       = EAG_S_OPND2;
               end
               else if (r_q.ind)
               begin
                  r_d.ptr = eag_page0(i_mem_rdata);
                  r_d.st = EAG_S_PTR1;
               end
               else
                  r_d.st = EAG_S_DONE;
            end
         end
         EAG_S_PTR1, EAG_S_PTR2:
         begin
            o_mem_req  = 1'b1;
            o_mem_addr = r_q.ptr;
            if (i_mem_ack)
            begin
               // a pointer at FF takes its low byte from 0100, no page wrap
               r_d.ptr = r_q.ptr + 16'h0001;
               if (r_q.st == EAG_S_PTR1)
               begin
                  r_d.val = {8'h00, i_mem_rdata};
                  if (r_q.ind_word)
                     r_d.st = EAG_S_PTR2;
                  else
                     r_d.st = EAG_S_DONE;
               end
               else
               begin
                  r_d.val = eag_join(r_q.val[7:0], i_mem_rdata);
                  r_d.st  = EAG_S_DONE;
               end
            end
         end
         EAG_S_DONE:
         begin
            // index add: 8-bit pointer or offset yields at most 1FE
            // relative base is pc past the operand bytes already read
            if (r_q.rel)
               r_d.ea = sum;
            else if (r_q.add_idx)
               r_d.ea = sum;
            else
               r_d.ea = r_q.val;
            r_d.done = 1'b1;
            r_d.st   = EAG_S_IDLE;
         end
         EAG_S_ERR:
         begin
            r_d.illegal = 1'b1;
            r_d.done    = 1'b1;
            r_d.st      = EAG_S_IDLE;
         end
         default:
            r_d.st = EAG_S_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         r_q          <= '0;
         r_q.st       <= EAG_S_IDLE;
      end
      else
         r_q <= r_d;
   end

   assign o_done     = r_q.done;
   assign o_illegal  = r_q.illegal;
   assign o_ea       = r_q.ea;
   assign o_opnd_len = r_q.len;
   assign o_use_y    = r_q.use_y;
   assign o_busy     = (r_q.st != EAG_S_IDLE);
endmodule

// [bench/eag_mem_model.sv]
// memory partner answering byte reads of the address generator
`timescale 1ns/1ns
module eag_mem_model
(
   input  wire logic        i_mclk,
   input  wire logic        i_slow,
   input  wire logic        i_req,
   input  wire logic [15:0] i_addr,
   output logic             o_ack,
   output logic [7:0]       o_rdata
);
   logic       tog_q = 1'b0;
   logic [7:0] byte_v;
   always @(posedge i_mclk) tog_q <= ~tog_q;
   assign byte_v = i_addr[7:0] ^ i_addr[15:8] ^ 8'hA5;
   // slow mode acks every other cycle
   assign o_ack = i_req && (!i_slow || tog_q);
   // inverted data off the ack so stale bytes never look valid
   assign o_rdata = o_ack ? byte_v : ~byte_v;
endmodule

// [bench/eag_core_sva.sv]
// port assertions for the effective-address generator
`timescale 1ns/1ns
module eag_core_sva
   import eag_pkg::*;
(
   input wire logic                i_mclk,
   input wire logic                i_sys_rst,
   input wire logic                i_start,
   input wire logic [7:0]          i_prefix,
   input wire logic                i_prefix_vld,
   input wire eag_pkg::eag_mode_t  i_mode,
   input wire eag_pkg::eag_class_t i_class,
   input wire logic [7:0]          i_x,
   input wire logic [7:0]          i_y,
   input wire logic [15:0]         i_pc,
   input wire logic                o_mem_req,
   input wire logic [15:0]         o_mem_addr,
   input wire logic                i_mem_ack,
   input wire logic [7:0]          i_mem_rdata,
   input wire logic                o_done,
   input wire logic                o_illegal,
   input wire logic [15:0]         o_ea,
   input wire logic [1:0]          o_opnd_len,
   input wire logic                o_use_y,
   input wire logic                o_busy
);
   default clocking dc @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   logic go;
   assign go = i_start && !o_busy;
   property p_dir_long;
      go && !i_prefix_vld && i_mode == EAG_M_DIR_L && i_class == EAG_C_ALU
         |=> o_mem_req && o_mem_addr == $past(i_pc);
   endproperty
   a_dir_long: assert property (p_dir_long) else $error("long direct read not at pc");
   property p_idx0;
      go && !i_prefix_vld && i_mode == EAG_M_IDX_0 && i_class != EAG_C_REL |=> !o_mem_req
         ##1 o_done && o_ea == {8'h00, $past(i_x, 2)} && o_opnd_len == EAG_LEN_NONE;
   endproperty
   a_idx0: assert property (p_idx0) else $error("no-offset index wrong");
   property p_long_ref;
      go && i_mode == EAG_M_IDX_L && i_class != EAG_C_ALU |=> !o_mem_req ##1 o_done && o_illegal;
   endproperty
   a_long_ref: assert property (p_long_ref) else $error("long form not refused");
   property p_rel_ref;
      go && ((i_mode == EAG_M_REL) != (i_class == EAG_C_REL)) |-> ##2 o_done && o_illegal;
   endproperty
   a_rel_ref: assert property (p_rel_ref) else $error("relative misuse not refused");
   property p_ptr;
      go && i_prefix_vld && i_prefix == EAG_PFX_IND && i_mode == EAG_M_IDX_S ##1 i_mem_ack
         |=> o_mem_req && o_mem_addr == {EAG_PAGE0_HI, $past(i_mem_rdata)};
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer not read from page zero");
   property p_use_y;
      go && i_prefix_vld && i_prefix == EAG_PFX_Y && i_mode == EAG_M_IDX_0 && i_class != EAG_C_REL
         |-> ##2 o_done && o_use_y && o_ea == {8'h00, $past(i_y, 2)};
   endproperty
   a_use_y: assert property (p_use_y) else $error("y prefix ignored");
   property p_ea_hold;
      !o_done |-> $stable(o_ea);
   endproperty
   a_ea_hold: assert property (p_ea_hold) else $error("address moved between completions");
   property p_ill_done;
      $rose(o_illegal) |-> o_done;
   endproperty
   a_ill_done: assert property (p_ill_done) else $error("refusal without done");
   c_ind: cover property (go && i_prefix_vld && i_prefix == EAG_PFX_IND);
   c_ill: cover property (o_done && o_illegal);
   c_wait: cover property (o_mem_req && !i_mem_ack);
endmodule
bind eag_core eag_core_sva sva_i (.*);

// [bench/testbench.sv]
// self-checking bench for the effective-address generator
`timescale 1ns/1ns
module testbench;
   import eag_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, start = 1'b0, pvld = 1'b0, slow = 1'b0;
   logic [7:0]  pfx = 8'h00, x = 8'h00, y = 8'h00, rd;
   logic [15:0] pc = 16'h0000, maddr, ea;
   eag_mode_t   mode = EAG_M_IDX_0;
   eag_class_t  cls = EAG_C_ALU;
   logic        req, ack, done, ill, usey, busy;
   logic [1:0]  len;
   int          miscompares = 0, check_count = 0, seed = 32'h4901, r, sel;
   always #20 clk = ~clk;
   eag_core uut (.i_mclk(clk), .i_sys_rst(rst), .i_start(start), .i_prefix(pfx),
      .i_prefix_vld(pvld), .i_mode(mode), .i_class(cls), .i_x(x), .i_y(y), .i_pc(pc),
      .o_mem_req(req), .o_mem_addr(maddr), .i_mem_ack(ack), .i_mem_rdata(rd), .o_done(done),
      .o_illegal(ill), .o_ea(ea), .o_opnd_len(len), .o_use_y(usey), .o_busy(busy));
   eag_mem_model mem (.i_mclk(clk), .i_slow(slow), .i_req(req), .i_addr(maddr), .o_ack(ack),
      .o_rdata(rd));
   function automatic logic [7:0] m(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic set(input logic v, input logic [7:0] p, input eag_mode_t md,
      input eag_class_t c, input logic [7:0] xi, input logic [15:0] pi);
      pvld = v;
      pfx = p;
      mode = md;
      cls = c;
      x = xi;
      y = ~xi;
      pc = pi;
   endtask
   task automatic run();
      logic        iy, ind, lng, bad;
      logic [7:0]  ix, b0, pb;
      logic [15:0] w, e;
      int          n;
      iy = pvld && (pfx == EAG_PFX_Y || pfx == EAG_PFX_IND_Y);
      ind = pvld && pfx != EAG_PFX_Y;
      lng = mode == EAG_M_DIR_L || mode == EAG_M_IDX_L;
      bad = (pvld && pfx == EAG_PFX_IND_Y && !(mode inside {EAG_M_IDX_S, EAG_M_IDX_L}))
         || (lng && cls != EAG_C_ALU) || ((mode == EAG_M_REL) != (cls == EAG_C_REL));
      ix = iy ? y : x;
      b0 = m(pc);
      pb = m({8'h00, b0});
      w = ind ? (lng ? {pb, m({8'h00, b0} + 16'h0001)} : {8'h00, pb})
         : (lng ? {b0, m(pc + 16'h0001)} : {8'h00, b0});
      // relative base is pc past the single operand byte
      e = mode == EAG_M_REL ? pc + 16'h0001 + {{8{w[7]}}, w[7:0]}
         : mode == EAG_M_IDX_0 ? {8'h00, ix}
         : (mode inside {EAG_M_IDX_S, EAG_M_IDX_L}) ? w + 16'(ix) : w;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      for (n = 0; n < 30 && done !== 1'b1; n++) @(negedge clk);
      if (done !== 1'b1)
      begin
         miscompares++;
         $display("mismatch at %0t: no completion", $time);
         wrap_up();
      end
      else
      begin
         chk(16'(ill), 16'(bad));
         if (!bad)
         begin
            chk(ea, e);
            chk(16'(len), mode == EAG_M_IDX_0 ? 16'h0 : (lng && !ind) ? 16'h2 : 16'h1);
            chk(16'(usey), 16'(iy));
         end
      end
   endtask
   initial
   begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      set(0, 8'h00, EAG_M_IDX_S, EAG_C_RMW, 8'hFF, 16'h005A); run();
      set(1, EAG_PFX_IND, EAG_M_IDX_S, EAG_C_ALU, 8'hFF, 16'h005A); run();
      set(1, EAG_PFX_Y, EAG_M_IDX_0, EAG_C_JMP, 8'h3C, 16'h0100); run();
      set(0, 8'h00, EAG_M_IDX_L, EAG_C_RMW, 8'h10, 16'h2000); run();
      set(1, EAG_PFX_IND, EAG_M_DIR_S, EAG_C_JMP, 8'h00, 16'h0040); run();
      set(1, EAG_PFX_IND_Y, EAG_M_IDX_L, EAG_C_ALU, 8'h80, 16'hFFFF); run();
      set(1, EAG_PFX_IND_Y, EAG_M_IDX_0, EAG_C_ALU, 8'h20, 16'h0300); run();
      set(0, 8'h00, EAG_M_REL, EAG_C_REL, 8'h00, 16'h0000); run();
      set(1, EAG_PFX_IND, EAG_M_REL, EAG_C_REL, 8'h00, 16'h7FFF); run();
      set(0, 8'h00, EAG_M_REL, EAG_C_ALU, 8'h00, 16'h0010); run();
      $display("corner tests done");
      repeat (300)
      begin
         r = $random(seed);
         mode = eag_mode_t'(4'(r[2:0] % 5 + 1));
         sel = r[4:3];
         if ((mode == EAG_M_IDX_0 && sel > 1) || (mode == EAG_M_REL && sel == 1))
            sel = 0;
         if (sel == 3 && r[5] && mode == EAG_M_DIR_L)
            mode = EAG_M_DIR_S;
         pvld = sel != 0;
         pfx = 8'h8F + 8'(sel);
         cls = eag_class_t'(r[7:6]);
         x = r[15:8];
         y = r[23:16];
         slow = r[24];
         pc = 16'($random(seed));
         run();
      end
      $display("random tests done");
      set(0, 8'h00, EAG_M_IDX_L, EAG_C_ALU, 8'h01, 16'h1234);
      slow = 1'b1;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      rst = 1'b1;
      repeat (3) @(negedge clk);
      chk(16'(busy), 16'h0000);
      chk(ea, 16'h0000);
      rst = 1'b0;
      run();
      $display("reset test done");
      wrap_up();
   end
endmodule
